// File: inc/dbg_cmd_regs.vh
`ifndef DBG_CMD_REGS_VH
`define DBG_CMD_REGS_VH
// command codes
`define CMD_RD_REGFILE    8'h09
`define CMD_WR_PROG       8'h0a
`define CMD_RD_PROG       8'h0b
`define CMD_WR_DATA       8'h0c
// value returned when access is blocked
`define BLOCKED_BYTE      8'hff
// transfer length picked by a size field of zero
`define SIZE_ZERO_WIDE    17'h10000
`define SIZE_ZERO_REG     17'h00100
// register-file address field: lower nibble of first byte
`define REG_ADDR_HI_BITS  3:0
`define REG_ADDR_HI_W     4
// memory space selects
`define SPACE_REG         2'h0
`define SPACE_PROG        2'h1
`define SPACE_DATA        2'h2
`endif

// File: rtl/byte_fifo.v
`timescale 1ns/1ps
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk_sys,
   input  wire             reset,
   input  wire             clk_en,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output reg  [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   wire            push = in_valid && in_ready;
   wire            pop  = out_valid && out_ready;

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});

   always @(posedge clk_sys) begin
      if (clk_en && push) begin
         mem[wr_q] <= in_data;
      end
   end

   // head word read straight from the array flops, no extra stage of latency
   always @* begin
      out_data = mem[rd_q];
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else if (clk_en) begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // byte_fifo

// File: rtl/debug_memory_command_engine.v
`timescale 1ns/1ps
`include "dbg_cmd_regs.vh"
module debug_memory_command_engine #(
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW    = 4
) (
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        clk_en,
   input  wire [7:0]  rx_byte,
   input  wire        rx_valid,
   output wire        rx_ready,
   output wire [7:0]  tx_byte,
   output wire        tx_valid,
   input  wire        tx_ready,
   input  wire        debug_halted,
   input  wire        read_lock,
   input  wire        flash_unlocked,
   output reg  [1:0]  mem_space,
   output reg  [15:0] mem_addr,
   output reg  [7:0]  mem_wdata,
   output reg         mem_wr,
   output reg         mem_rd,
   input  wire [7:0]  mem_rdata,
   input  wire        mem_ack,
   output wire        busy
);
   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam [3:0] S_CMD   = 4'h0;
   localparam [3:0] S_AH    = 4'h1;
   localparam [3:0] S_AL    = 4'h2;
   localparam [3:0] S_SH    = 4'h3;
   localparam [3:0] S_SL    = 4'h4;
   localparam [3:0] S_WDAT  = 4'h5;
   localparam [3:0] S_WMEM  = 4'h6;
   localparam [3:0] S_RMEM  = 4'h7;
   localparam [3:0] S_RPUSH = 4'h8;

   reg [3:0]  state_q;
   reg [7:0]  cmd_q;
   reg [16:0] left_q;
   reg [7:0]  rdata_q;
   reg        push_q;

   wire blocked = !debug_halted || read_lock;
   wire fifo_ready;

   // zero size field selects the largest transfer
   function [16:0] size_count;
      input [15:0] sz;
      input        wide;
      begin
         if (sz == 16'h0000) begin
            size_count = wide ? `SIZE_ZERO_WIDE : `SIZE_ZERO_REG;
         end else begin
            size_count = {1'b0, sz};
         end
      end
   endfunction

   function is_write;
      input [7:0] c;
      begin
         is_write = (c == `CMD_WR_PROG) || (c == `CMD_WR_DATA);
      end
   endfunction

   // ----------------------------------------------------------------
   // receive side: framing lives in the serial front end
   // ----------------------------------------------------------------
   // framed bytes arrive already deserialised, lsb first
   assign rx_ready = (state_q == S_CMD) || (state_q == S_AH) || (state_q == S_AL)
                     || (state_q == S_SH) || (state_q == S_SL) || (state_q == S_WDAT);
   assign busy     = (state_q != S_CMD);

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q   <= S_CMD;
         cmd_q     <= 8'h00;
         left_q    <= 17'h00000;
         rdata_q   <= 8'h00;
         push_q    <= 1'b0;
         mem_space <= `SPACE_REG;
         mem_addr  <= 16'h0000;
         mem_wdata <= 8'h00;
         mem_wr    <= 1'b0;
         mem_rd    <= 1'b0;
      end else if (clk_en) begin
         if (push_q && fifo_ready) begin
            push_q <= 1'b0;
         end
         case (state_q)
            S_CMD: begin
               if (rx_valid) begin
                  cmd_q <= rx_byte;
                  case (rx_byte)
                     `CMD_RD_REGFILE: begin
                        mem_space <= `SPACE_REG;
                        state_q   <= S_AH;
                     end
                     `CMD_WR_PROG, `CMD_RD_PROG: begin
                        mem_space <= `SPACE_PROG;
                        state_q   <= S_AH;
                     end
                     `CMD_WR_DATA: begin
                        mem_space <= `SPACE_DATA;
                        state_q   <= S_AH;
                     end
                     default: begin
                        state_q <= S_CMD; // unknown codes ignored
                     end
                  endcase
               end
            end
            S_AH: begin
               if (rx_valid) begin
                  if (cmd_q == `CMD_RD_REGFILE) begin
                     mem_addr[15:8] <= {4'h0, rx_byte[`REG_ADDR_HI_BITS]};
                  end else begin
                     mem_addr[15:8] <= rx_byte;
                  end
                  state_q <= S_AL;
               end
            end
            S_AL: begin
               if (rx_valid) begin
                  mem_addr[7:0] <= rx_byte;
                  // register read carries a single size byte
                  state_q <= (cmd_q == `CMD_RD_REGFILE) ? S_SL : S_SH;
               end
            end
            S_SH: begin
               if (rx_valid) begin
                  left_q[15:8] <= rx_byte;
                  state_q      <= S_SL;
               end
            end
            S_SL: begin
               if (rx_valid) begin
                  if (cmd_q == `CMD_RD_REGFILE) begin
                     left_q <= size_count({8'h00, rx_byte}, 1'b0);
                  end else begin
                     left_q <= size_count({left_q[15:8], rx_byte}, 1'b1);
                  end
                  state_q <= is_write(cmd_q) ? S_WDAT : S_RMEM;
               end
            end
            S_WDAT: begin
               if (rx_valid) begin
                  mem_wdata <= rx_byte;
                  // drop the byte but still count it down
                  if (blocked || (cmd_q == `CMD_WR_PROG && !flash_unlocked)) begin
                     mem_addr <= mem_addr + 16'h0001;
                     left_q   <= left_q - 17'h00001;
                     state_q  <= (left_q == 17'h00001) ? S_CMD : S_WDAT;
                  end else begin
                     mem_wr  <= 1'b1;
                     state_q <= S_WMEM;
                  end
               end
            end
            S_WMEM: begin
               if (mem_ack) begin
                  mem_wr   <= 1'b0;
                  mem_addr <= mem_addr + 16'h0001;
                  left_q   <= left_q - 17'h00001;
                  state_q  <= (left_q == 17'h00001) ? S_CMD : S_WDAT;
               end
            end
            S_RMEM: begin
               if (!push_q) begin
                  if (blocked) begin
                     rdata_q <= `BLOCKED_BYTE;
                     push_q  <= 1'b1;
                     state_q <= S_RPUSH;
                  end else if (mem_rd && mem_ack) begin
                     mem_rd  <= 1'b0;
                     rdata_q <= mem_rdata;
                     push_q  <= 1'b1;
                     state_q <= S_RPUSH;
                  end else begin
                     mem_rd <= 1'b1;
                  end
               end
            end
            S_RPUSH: begin
               // one byte per count; fifo back-pressure stalls reads
               mem_addr <= mem_addr + 16'h0001;
               left_q   <= left_q - 17'h00001;
               state_q  <= (left_q == 17'h00001) ? S_CMD : S_RMEM;
            end
            default: begin
               state_q <= S_CMD;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // reply buffer toward the serial transmitter
   // ----------------------------------------------------------------
   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_reply_fifo (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .clk_en    (clk_en),
      .in_data   (rdata_q),
      .in_valid  (push_q),
      .in_ready  (fifo_ready),
      .out_data  (tx_byte),
      .out_valid (tx_valid),
      .out_ready (tx_ready)
   );
endmodule // debug_memory_command_engine

// File: verification/engine_chk.sv
`timescale 1ns/1ps
`include "dbg_cmd_regs.vh"
module engine_chk (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        rx_ready,
   input wire logic [7:0]  tx_byte,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic        debug_halted,
   input wire logic        read_lock,
   input wire logic        flash_unlocked,
   input wire logic [1:0]  mem_space,
   input wire logic        mem_wr,
   input wire logic        mem_rd,
   input wire logic        mem_ack,
   input wire logic        busy
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_wr_holds: assert property (mem_wr && !mem_ack |=> mem_wr) else $error("write dropped early");
   a_rd_holds: assert property (mem_rd && !mem_ack |=> mem_rd) else $error("read dropped early");
   a_wr_allowed: assert property ($rose(mem_wr) |-> debug_halted && !read_lock)
      else $error("write while blocked");
   a_prog_unlocked: assert property ($rose(mem_wr) && mem_space == `SPACE_PROG |-> flash_unlocked)
      else $error("program write while flash locked");
   a_rd_allowed: assert property ($rose(mem_rd) |-> debug_halted && !read_lock)
      else $error("read while blocked");
   a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("reply byte changed while stalled");
   a_rd_space: assert property ($rose(mem_rd) |-> mem_space != `SPACE_DATA) else $error("data read");
   a_wr_space: assert property ($rose(mem_wr) |-> mem_space != `SPACE_REG) else $error("regfile write");
endmodule // engine_chk
bind debug_memory_command_engine engine_chk chk_i (.clk_sys, .reset, .rx_ready, .tx_byte, .tx_valid, .tx_ready,
   .debug_halted, .read_lock, .flash_unlocked, .mem_space, .mem_wr, .mem_rd, .mem_ack, .busy);

// File: verification/mem_partner.sv
`timescale 1ns/1ps
module mem_partner (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        clk_en,
   input wire logic        slow,
   input wire logic        mem_wr,
   input wire logic        mem_rd,
   input wire logic [1:0]  mem_space,
   input wire logic [15:0] mem_addr,
   output logic     [7:0]  mem_rdata,
   output logic            mem_ack
);
   logic [1:0] wait_q;
   // outside the ack cycle the data is the inverse, never a stale match
   assign mem_rdata = (mem_addr[7:0] ^ mem_addr[15:8] ^ {6'h0, mem_space}) ^ {8{!mem_ack}};
   // ack only while the engine runs, else it would miss the pulse
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mem_ack <= 1'b0;
         wait_q  <= 2'h0;
      end else if (clk_en) begin
         if (mem_ack) begin
            mem_ack <= 1'b0;
            wait_q  <= slow ? 2'h3 : 2'h0;
         end else if ((mem_wr || mem_rd) && wait_q == 2'h0) mem_ack <= 1'b1;
         else if (mem_wr || mem_rd) wait_q <= wait_q - 2'h1;
      end
   end
endmodule // mem_partner

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
   logic        clk_sys = 0, reset = 1, clk_en = 1, rx_valid = 0, tx_ready = 0, slow = 0, stall = 0;
   logic        debug_halted = 1, read_lock = 0, flash_unlocked = 1;
   logic [7:0]  rx_byte = 0, tx_byte, mem_wdata, mem_rdata, txq[$], exp_tx[$];
   logic        rx_ready, tx_valid, mem_wr, mem_rd, mem_ack, busy;
   logic [1:0]  mem_space;
   logic [15:0] mem_addr;
   logic [25:0] wrq[$], exp_wr[$];
   logic [31:0] seed = 97;
   int          error_cnt = 0, check_count = 0;
   always #5 clk_sys = ~clk_sys;
   debug_memory_command_engine DUT (.clk_sys, .reset, .clk_en, .rx_byte, .rx_valid, .rx_ready, .tx_byte,
      .tx_valid, .tx_ready, .debug_halted, .read_lock, .flash_unlocked, .mem_space, .mem_addr, .mem_wdata,
      .mem_wr, .mem_rd, .mem_rdata, .mem_ack, .busy);
   mem_partner mem (.clk_sys, .reset, .clk_en, .slow, .mem_wr, .mem_rd, .mem_space, .mem_addr, .mem_rdata,
      .mem_ack);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   always @(posedge clk_sys) begin
      if (!reset && clk_en && tx_valid && tx_ready) txq.push_back(tx_byte);
      if (!reset && clk_en && mem_wr && mem_ack) wrq.push_back({mem_space, mem_addr, mem_wdata});
      #1;
      tx_ready = !stall && rnd() % 4 != 0;
      clk_en = rnd() % 8 != 0;
      slow = rnd() % 2;
   end
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic send(logic [7:0] b);
      rx_byte = b;
      rx_valid = 1;
      do @(negedge clk_sys); while (!(rx_ready && clk_en));
      @(posedge clk_sys);
      #1;
   endtask
   // ----------------------------------------
   // one framed command, expectations built alongside
   // ----------------------------------------
   function automatic logic [7:0] rd_exp(logic [15:0] x, logic [1:0] sp, logic ok);
      return ok ? x[7:0] ^ x[15:8] ^ {6'h0, sp} : 8'hff;
   endfunction
   // cut_at above zero moves only that many bytes, then a reset cuts the command
   task automatic run(logic [7:0] c, logic [15:0] a, logic [15:0] sz, int cut_at = 0);
      int n;
      logic ok;
      logic [7:0] d;
      logic [15:0] x;
      logic [1:0] sp;
      n = (c == 8'h09) ? ((sz[7:0] == 0) ? 256 : sz[7:0]) : ((sz == 0) ? 65536 : sz);
      if (cut_at != 0) n = cut_at;
      ok = debug_halted && !read_lock && !(c == 8'h0a && !flash_unlocked);
      sp = (c == 8'h09) ? 2'h0 : (c == 8'h0c) ? 2'h2 : 2'h1;
      x = (c == 8'h09) ? {4'h0, a[11:0]} : a;
      send(c);
      send(c == 8'h09 ? {4'h0, a[11:8]} : a[15:8]);
      send(a[7:0]);
      if (c != 8'h09) send(sz[15:8]);
      send(sz[7:0]);
      for (int i = 0; i < n; i++) begin
         if (c[0]) exp_tx.push_back(rd_exp(x, sp, ok));
         else begin
            d = 8'(rnd());
            send(d);
            if (ok) exp_wr.push_back({sp, x, d});
         end
         x++;
      end
      rx_valid = 0;
      for (int k = 0; k < 4000 && ((busy && cut_at == 0) || txq.size() < exp_tx.size()
                                   || wrq.size() < exp_wr.size()); k++) begin
         @(negedge clk_sys);
         if (k == 100) stall = 0;
      end
      chk(txq.size(), exp_tx.size());
      chk(wrq.size(), exp_wr.size());
      foreach (exp_tx[i]) if (i < txq.size()) chk(txq[i], exp_tx[i]);
      foreach (exp_wr[i]) if (i < wrq.size()) chk(wrq[i], exp_wr[i]);
      if (cut_at != 0) begin
         chk(busy, 1);
         @(posedge clk_sys);
         #1 reset = 1;
         repeat (2) @(posedge clk_sys);
         #1 reset = 0;
      end
      chk({busy, tx_valid, mem_wr, mem_rd, rx_ready}, 5'h01);
      txq = {};
      exp_tx = {};
      wrq = {};
      exp_wr = {};
      @(posedge clk_sys);
      #1;
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // about six thousand cycles expected; generous margin
   initial begin
      #500000;
      error_cnt++;
      conclude;
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      #1 reset = 0;
      run(8'h09, 16'h03fe, 16'h0004);
      stall = 1;
      run(8'h09, 16'h0f80, 16'h0000);
      run(8'h0b, 16'hfffe, 16'h0003);
      run(8'h0a, 16'h0010, 16'h0003);
      send(8'h55);
      run(8'h0c, 16'h1234, 16'h0002);
      read_lock = 1;
      for (int i = 0; i < 4; i++) run(8'h09 + 8'(i), 16'h0100, 16'h0003);
      read_lock = 0;
      debug_halted = 0;
      for (int i = 0; i < 4; i++) run(8'h09 + 8'(i), 16'h0200, 16'h0002);
      debug_halted = 1;
      flash_unlocked = 0;
      run(8'h0a, 16'h0300, 16'h0002);
      run(8'h0c, 16'h0300, 16'h0002);
      run(8'h0a, 16'hff00, 16'h0000, 300);
      flash_unlocked = 1;
      run(8'h0b, 16'hfff0, 16'h0000, 300);
      run(8'h0c, 16'h00f8, 16'h0000, 300);
      repeat (10) begin
         {debug_halted, read_lock, flash_unlocked} = 3'(rnd()) | 3'h5;
         run(8'h09 + 8'(rnd() % 4), 16'(rnd()), 16'(rnd() % 20 + 1));
      end
      conclude;
   end
endmodule // tb
